//--- rtl/lin_cfg_pkg.sv
// Purpose: Shared constants and types for the LIN channel timing configuration block
// Assumes: Four identical channels, byte-wide register port
// Notes: Addresses are those of channel 0; later channels add a multiple of the stride
package lin_cfg_pkg;

  // ----------------------------------------
  // Channel layout
  // ----------------------------------------
  localparam int NUM_CH = 4;
  localparam logic [7:0] CH_STRIDE = 8'h30;

  // ----------------------------------------
  // Register addresses, channel 0
  // ----------------------------------------
  localparam logic [7:0] ADDR_IDLE_TIMEOUT_CONTROL = 8'h32;
  localparam logic [7:0] ADDR_GLOBAL_CHANNEL_CONTROL = 8'h33;
  localparam logic [7:0] ADDR_RESPONSE_TIMEOUT_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_BAUD_FRACTION = 8'h35;
  localparam logic [7:0] ADDR_BAUD_DIVISOR_HIGH = 8'h36;
  localparam logic [7:0] ADDR_BAUD_DIVISOR_LOW = 8'h37;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int IDLE_RESET_ENABLE_BIT = 1;
  localparam int STOP_BITS_BIT = 1;
  localparam int SOFT_RESET_BIT = 0;
  localparam int RESPONSE_LIMIT_MSB = 3;
  localparam int BAUD_FRACTION_MSB = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic IDLE_RESET_ENABLE_RESET = 1'b1;
  localparam logic STOP_BITS_RESET = 1'b0;
  localparam logic SOFT_RESET_RESET = 1'b0;
  localparam logic [3:0] RESPONSE_LIMIT_RESET = 4'hE;
  localparam logic [3:0] BAUD_FRACTION_RESET = 4'h0;
  localparam logic [15:0] INTEGER_DIVISOR_RESET = 16'h0000;

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam logic [3:0] TICKS_PER_BIT_LAST = 4'hF;
  localparam logic [7:0] RESPONSE_EXTRA_BYTES = 8'h02;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [0:0] {
    TMR_IDLE = 1'b0,
    TMR_RUN = 1'b1
  } resp_state_t;

endpackage

//--- rtl/baud_gen.sv
// Purpose: Fractional baud generator giving one tick per sixteenth of a bit
// Assumes: clk_sys is the PLL output clock
// Notes: Each tick period is divisor cycles plus one when the fraction accumulator carries
module baud_gen
  import lin_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hold,
  input wire logic [15:0] integer_divisor,
  input wire logic [3:0] baud_fraction_value,
  output logic tick_q
);

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [3:0] acc_q;
  logic [3:0] acc_d;
  logic tick_d;
  logic [4:0] acc_sum;

  // ----------------------------------------
  // Divider
  // ----------------------------------------
  always_comb begin
    acc_sum = {1'b0, acc_q} + {1'b0, baud_fraction_value};
    cnt_d = cnt_q;
    acc_d = acc_q;
    tick_d = 1'b0;
    if (hold || integer_divisor == INTEGER_DIVISOR_RESET) begin
      cnt_d = '0;
      acc_d = '0;
    end else if (cnt_q == 16'h0000) begin
      // 16 ticks span 16 x divisor + fraction cycles
      tick_d = 1'b1;
      acc_d = acc_sum[3:0];
      cnt_d = integer_divisor - 16'h0001 + {15'h0000, acc_sum[4]};
    end else begin
      cnt_d = cnt_q - 16'h0001;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= '0;
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      tick_q <= tick_d;
    end
  end

endmodule

//--- rtl/resp_timer.sv
// Purpose: Response timeout timer counted in nominal bit times
// Assumes: tick is the 16x oversampling tick of the same channel
// Notes: A new header end restarts the count
module resp_timer
  import lin_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic hold,
  input wire logic tick,
  input wire logic header_done,
  input wire logic response_done,
  input wire logic [3:0] response_limit,
  input wire logic [3:0] data_byte_count,
  output logic expire_q
);

  resp_state_t state_q;
  resp_state_t state_d;
  logic [3:0] sub_q;
  logic [3:0] sub_d;
  logic [7:0] bits_q;
  logic [7:0] bits_d;
  logic expire_d;
  logic [7:0] limit_bits;

  // ----------------------------------------
  // Limit and counting
  // ----------------------------------------
  always_comb begin
    // Limit is response_limit x (bytes + 2) bit times
    limit_bits = {4'h0, response_limit} * ({4'h0, data_byte_count} + RESPONSE_EXTRA_BYTES);
    state_d = state_q;
    sub_d = sub_q;
    bits_d = bits_q;
    expire_d = 1'b0;
    if (hold) begin
      state_d = TMR_IDLE;
    end else if (header_done) begin
      state_d = TMR_RUN;
      sub_d = '0;
      bits_d = '0;
    end else begin
      case (state_q)
        TMR_IDLE: begin
          state_d = TMR_IDLE;
        end
        TMR_RUN: begin
          if (response_done) begin
            state_d = TMR_IDLE;
          end else if (tick) begin
            sub_d = sub_q + 4'h1;
            if (sub_q == TICKS_PER_BIT_LAST) begin
              bits_d = bits_q + 8'h01;
              if (bits_d >= limit_bits) begin
                expire_d = 1'b1;
                state_d = TMR_IDLE;
              end
            end
          end
        end
        default: begin
          state_d = TMR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= TMR_IDLE;
      sub_q <= '0;
      bits_q <= '0;
      expire_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sub_q <= sub_d;
      bits_q <= bits_d;
      expire_q <= expire_d;
    end
  end

endmodule

//--- rtl/lin_channel_timing_config.sv
// Purpose: Per-channel initialization settings, response timer and baud generator
// Assumes: Register port is the internal side of the serial register interface
// Notes: Four channels at a fixed address stride; reads answer one cycle later
// Notes: Response limit accepts writes in every mode
//
// How it works
// - Idle timeout resets state machine when enabled
// - Idle reset enable writable only in init
// - Stop setting selects one or two stop bits
// - Soft reset clears controller, keeps configuration
// - Soft reset clears status and error bits
// - Soft reset bit cleared only by software
// - Stop, soft reset, baud fields init-only
// - Init request ignored while sleep selected
// - Response timer counts bits from header end
// - Timeout at limit times bytes plus two
// - Response limit four bits, resets to 14
// - Baud is 16-bit integer, 4-bit fraction
// - Divisor built from high and low bytes
// - Baud tick at sixteen times baud rate
// - Zero divisor stops the LIN clock
// - Init request bit selects initialization mode
// - Byte count is programmed data length
// - Timeout expiry sets timeout error flag
module lin_channel_timing_config
  import lin_cfg_pkg::*;
(
  // ----------------------------------------
  // Clock and reset
  // ----------------------------------------
  input wire logic clk_sys,
  input wire logic rst,
  // ----------------------------------------
  // Register port
  // ----------------------------------------
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data_q,
  output logic reg_rd_valid_q,
  // ----------------------------------------
  // Channel inputs
  // ----------------------------------------
  input wire logic [NUM_CH-1:0] init_request,
  input wire logic [NUM_CH-1:0] sleep_select,
  input wire logic [NUM_CH-1:0] idle_timeout_event,
  input wire logic [NUM_CH-1:0] header_done,
  input wire logic [NUM_CH-1:0] response_done,
  input wire logic [4*NUM_CH-1:0] data_byte_count,
  input wire logic [NUM_CH-1:0] timeout_flag_clear,
  // ----------------------------------------
  // Channel outputs
  // ----------------------------------------
  output logic [NUM_CH-1:0] init_mode_q,
  output logic [NUM_CH-1:0] two_stop_bits_q,
  output logic [NUM_CH-1:0] soft_reset_q,
  output logic [NUM_CH-1:0] fsm_idle_reset_q,
  output logic [NUM_CH-1:0] lin_clock_enable_q,
  output logic [NUM_CH-1:0] baud_tick_q,
  output logic [NUM_CH-1:0] timeout_error_flag_q
);

  // ----------------------------------------
  // Per-channel read views
  // ----------------------------------------
  logic [7:0] ch_rd_word [NUM_CH];
  logic [NUM_CH-1:0] ch_rd_hit;

  genvar k;
  generate
    for (k = 0; k < NUM_CH; k++) begin : g_ch
      localparam logic [7:0] BASE = 8'(k * CH_STRIDE);
      logic sel_idle;
      logic sel_glob;
      logic sel_resp;
      logic sel_frac;
      logic sel_divh;
      logic sel_divl;
      logic wr_idle;
      logic wr_glob;
      logic wr_resp;
      logic wr_frac;
      logic wr_divh;
      logic wr_divl;
      logic init_mode;
      logic idle_rst_en_q;
      logic idle_rst_en_d;
      logic stop2_q;
      logic stop2_d;
      logic sr_q;
      logic sr_d;
      logic [3:0] limit_q;
      logic [3:0] limit_d;
      logic [3:0] frac_q;
      logic [3:0] frac_d;
      logic [15:0] div_q;
      logic [15:0] div_d;
      logic tof_q;
      logic tof_d;
      logic idle_pulse_q;
      logic idle_pulse_d;
      logic init_q;
      logic init_d;
      logic clk_en_q;
      logic clk_en_d;
      logic tick;
      logic expire;
      logic rd_hit;
      logic [7:0] rd_word;

      // ----------------------------------------
      // Address decode
      // ----------------------------------------
      // Each channel sits one stride above the previous
      assign sel_idle = reg_addr == ADDR_IDLE_TIMEOUT_CONTROL + BASE;
      assign sel_glob = reg_addr == ADDR_GLOBAL_CHANNEL_CONTROL + BASE;
      assign sel_resp = reg_addr == ADDR_RESPONSE_TIMEOUT_CONTROL + BASE;
      assign sel_frac = reg_addr == ADDR_BAUD_FRACTION + BASE;
      assign sel_divh = reg_addr == ADDR_BAUD_DIVISOR_HIGH + BASE;
      assign sel_divl = reg_addr == ADDR_BAUD_DIVISOR_LOW + BASE;
      assign init_mode = init_request[k] & ~sleep_select[k];

      // ----------------------------------------
      // Write strobes
      // ----------------------------------------
      // Init-only fields need init mode at the write edge
      assign wr_idle = reg_wr_en & init_mode & sel_idle;
      assign wr_glob = reg_wr_en & init_mode & sel_glob;
      assign wr_resp = reg_wr_en & sel_resp;
      assign wr_frac = reg_wr_en & init_mode & sel_frac;
      assign wr_divh = reg_wr_en & init_mode & sel_divh;
      assign wr_divl = reg_wr_en & init_mode & sel_divl;

      // ----------------------------------------
      // Configuration registers
      // ----------------------------------------
      always_comb begin
        idle_rst_en_d = idle_rst_en_q;
        stop2_d = stop2_q;
        sr_d = sr_q;
        limit_d = limit_q;
        frac_d = frac_q;
        div_d = div_q;
        if (wr_idle) begin
          idle_rst_en_d = reg_wr_data[IDLE_RESET_ENABLE_BIT];
        end
        if (wr_glob) begin
          stop2_d = reg_wr_data[STOP_BITS_BIT];
          sr_d = reg_wr_data[SOFT_RESET_BIT];
        end
        if (wr_frac) begin
          frac_d = reg_wr_data[BAUD_FRACTION_MSB:0];
        end
        if (wr_divh) begin
          div_d[15:8] = reg_wr_data;
        end
        if (wr_divl) begin
          div_d[7:0] = reg_wr_data;
        end
        // Response limit is writable in every mode
        if (wr_resp) begin
          limit_d = reg_wr_data[RESPONSE_LIMIT_MSB:0];
        end
      end

      // Soft reset leaves every configuration register alone
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          idle_rst_en_q <= IDLE_RESET_ENABLE_RESET;
          stop2_q <= STOP_BITS_RESET;
          sr_q <= SOFT_RESET_RESET;
          limit_q <= RESPONSE_LIMIT_RESET;
          frac_q <= BAUD_FRACTION_RESET;
          div_q <= INTEGER_DIVISOR_RESET;
        end else begin
          idle_rst_en_q <= idle_rst_en_d;
          stop2_q <= stop2_d;
          sr_q <= sr_d;
          limit_q <= limit_d;
          frac_q <= frac_d;
          div_q <= div_d;
        end
      end

      // ----------------------------------------
      // Timers
      // ----------------------------------------
      // Soft reset holds both timers at their start
      baud_gen u_baud (
        .clk_sys(clk_sys),
        .rst(rst),
        .hold(sr_q),
        .integer_divisor(div_q),
        .baud_fraction_value(frac_q),
        .tick_q(tick)
      );

      resp_timer u_resp (
        .clk_sys(clk_sys),
        .rst(rst),
        .hold(sr_q),
        .tick(tick),
        .header_done(header_done[k]),
        .response_done(response_done[k]),
        .response_limit(limit_q),
        .data_byte_count(data_byte_count[4*k +: 4]),
        .expire_q(expire)
      );

      // ----------------------------------------
      // Status and control outputs
      // ----------------------------------------
      always_comb begin
        // Expiry beats a clear in the same cycle
        tof_d = expire | (tof_q & ~timeout_flag_clear[k] & ~sr_q);
        idle_pulse_d = idle_timeout_event[k] & idle_rst_en_q & ~sr_q;
        clk_en_d = div_q != INTEGER_DIVISOR_RESET;
        init_d = init_mode;
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          tof_q <= 1'b0;
          idle_pulse_q <= 1'b0;
          clk_en_q <= 1'b0;
          init_q <= 1'b0;
        end else begin
          tof_q <= tof_d;
          idle_pulse_q <= idle_pulse_d;
          clk_en_q <= clk_en_d;
          init_q <= init_d;
        end
      end

      // ----------------------------------------
      // Output wiring
      // ----------------------------------------
      assign timeout_error_flag_q[k] = tof_q;
      assign fsm_idle_reset_q[k] = idle_pulse_q;
      assign lin_clock_enable_q[k] = clk_en_q;
      assign two_stop_bits_q[k] = stop2_q;
      assign soft_reset_q[k] = sr_q;
      assign baud_tick_q[k] = tick;
      assign init_mode_q[k] = init_q;

      // ----------------------------------------
      // Read view
      // ----------------------------------------
      // Reads see registered values, so a same-cycle write is not seen
      always_comb begin
        rd_hit = 1'b1;
        rd_word = 8'h00;
        if (sel_idle) begin
          rd_word[IDLE_RESET_ENABLE_BIT] = idle_rst_en_q;
        end else if (sel_glob) begin
          rd_word[STOP_BITS_BIT] = stop2_q;
          rd_word[SOFT_RESET_BIT] = sr_q;
        end else if (sel_resp) begin
          rd_word[RESPONSE_LIMIT_MSB:0] = limit_q;
        end else if (sel_frac) begin
          rd_word[BAUD_FRACTION_MSB:0] = frac_q;
        end else if (sel_divh) begin
          rd_word = div_q[15:8];
        end else if (sel_divl) begin
          rd_word = div_q[7:0];
        end else begin
          rd_hit = 1'b0;
        end
      end

      assign ch_rd_hit[k] = rd_hit;
      assign ch_rd_word[k] = rd_word;
    end
  endgenerate

  // ----------------------------------------
  // Read data return
  // ----------------------------------------
  logic [7:0] rd_data_d;
  logic rd_valid_d;

  always_comb begin
    rd_data_d = 8'h00;
    // Channel windows never overlap, so the OR acts as a mux
    for (int i = 0; i < NUM_CH; i++) begin
      if (ch_rd_hit[i]) begin
        rd_data_d = rd_data_d | ch_rd_word[i];
      end
    end
    if (!reg_rd_en) begin
      rd_data_d = 8'h00;
    end
    rd_valid_d = reg_rd_en;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rd_data_q <= 8'h00;
      reg_rd_valid_q <= 1'b0;
    end else begin
      reg_rd_data_q <= rd_data_d;
      reg_rd_valid_q <= rd_valid_d;
    end
  end

endmodule

//--- sim/lin_channel_timing_config_asserts.sv
// Purpose: Port checker for the channel timing configuration block
// Assumes: Bound to lin_channel_timing_config, one clock domain
// Notes: Soft reset set and clear, stop and flag relations are checked on channel 0; the others on every channel
module lin_cfg_checker
  import lin_cfg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_rd_data_q,
  input wire logic reg_rd_valid_q,
  input wire logic [NUM_CH-1:0] init_request,
  input wire logic [NUM_CH-1:0] sleep_select,
  input wire logic [NUM_CH-1:0] idle_timeout_event,
  input wire logic [NUM_CH-1:0] timeout_flag_clear,
  input wire logic [NUM_CH-1:0] init_mode_q,
  input wire logic [NUM_CH-1:0] two_stop_bits_q,
  input wire logic [NUM_CH-1:0] soft_reset_q,
  input wire logic [NUM_CH-1:0] fsm_idle_reset_q,
  input wire logic [NUM_CH-1:0] lin_clock_enable_q,
  input wire logic [NUM_CH-1:0] baud_tick_q,
  input wire logic [NUM_CH-1:0] timeout_error_flag_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cfg_wr0;
  assign cfg_wr0 = reg_wr_en && reg_addr == ADDR_GLOBAL_CHANNEL_CONTROL && init_request[0]
    && !sleep_select[0];
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_read_answer: assert property (reg_rd_en |=> reg_rd_valid_q)
    else $error("read not answered");
  a_read_quiet: assert property (!reg_rd_valid_q |-> reg_rd_data_q == 8'h00)
    else $error("read data not zero when idle");
  a_init_follow: assert property (!$past(rst)
    |-> init_mode_q == ($past(init_request) & ~$past(sleep_select)))
    else $error("init mode wrong");
  a_idle_cause: assert property (
    (fsm_idle_reset_q & ~($past(idle_timeout_event) & ~$past(soft_reset_q))) == '0)
    else $error("idle reset without cause");
  a_zero_divisor: assert property (
    (baud_tick_q & ~(lin_clock_enable_q | $past(lin_clock_enable_q))) == '0)
    else $error("tick with zero divisor");
  a_soft_ticks: assert property (
    (baud_tick_q & soft_reset_q & $past(soft_reset_q)) == '0)
    else $error("tick during soft reset");
  a_soft_set: assert property ($rose(soft_reset_q[0])
    |-> $past(cfg_wr0) && $past(reg_wr_data[0]))
    else $error("soft reset set without init write");
  a_soft_hold: assert property ($fell(soft_reset_q[0])
    |-> $past(cfg_wr0) && !$past(reg_wr_data[0]))
    else $error("soft reset cleared by hardware");
  a_stop_init: assert property ($changed(two_stop_bits_q[0]) |-> $past(cfg_wr0))
    else $error("stop setting changed outside init write");
  a_flag_sticky: assert property ($fell(timeout_error_flag_q[0])
    |-> $past(timeout_flag_clear[0]) || $past(soft_reset_q[0]))
    else $error("timeout flag fell by itself");
  a_flag_soft: assert property (soft_reset_q[0] [*4] |-> !timeout_error_flag_q[0])
    else $error("flag kept through soft reset");
  c_read: cover property (reg_rd_valid_q);
  c_idle: cover property (fsm_idle_reset_q[0]);
  c_flag: cover property ($rose(timeout_error_flag_q[0]));
endmodule

//--- sim/lin_host_model.sv
// Purpose: Microcontroller model driving the register port
// Assumes: Requests launched 1 ns after a rising edge
// Notes: Idle lines carry the inverse of the last value
module lin_host_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic reg_wr_en,
  output logic [7:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [7:0] reg_rd_data_q,
  input wire logic reg_rd_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_wr_en = 1'b0;
    reg_addr = ~a;
    reg_wr_data = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk_sys);
    #1;
    reg_rd_en = 1'b0;
    reg_addr = ~a;
    d = reg_rd_data_q;
    v = reg_rd_valid_q;
  endtask
endmodule

//--- sim/lin_channel_timing_config_tb.sv
// Purpose: Self-checking bench for the channel timing configuration block
// Assumes: Divisor 3 with fraction 8 gives a 56-cycle bit
// Notes: Channel 0 carries the timing tests
module lin_channel_timing_config_tb
  import lin_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data_q, rv;
  logic reg_wr_en, reg_rd_en, reg_rd_valid_q, vv;
  logic [3:0] init_request = '0, sleep_select = '0, idle_timeout_event = '0;
  logic [3:0] header_done = '0, response_done = '0, timeout_flag_clear = '0;
  logic [15:0] data_byte_count = '0;
  logic [3:0] init_mode_q, two_stop_bits_q, soft_reset_q, fsm_idle_reset_q;
  logic [3:0] lin_clock_enable_q, baud_tick_q, timeout_error_flag_q;
  logic [7:0] rst_tab [6] = '{8'h02, 8'h00, 8'h0E, 8'h00, 8'h00, 8'h00};
  logic [7:0] ref_tab [6] = '{8'h02, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00};
  logic [7:0] wr_tab [6] = '{8'hFF, 8'hFE, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
  logic [7:0] ini_tab [6] = '{8'h02, 8'h02, 8'h0F, 8'h0F, 8'hFF, 8'hFF};
  int fails = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ticks = 0;
  int idle_ticks = 0;
  lin_channel_timing_config i_lin_channel_timing_config (.*);
  lin_host_model i_lin_host_model (.*);
  always #25 clk_sys = ~clk_sys;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] ra(input int k, input int r);
    return ADDR_IDLE_TIMEOUT_CONTROL + 8'(r) + 8'(k) * CH_STRIDE;
  endfunction
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_lin_host_model.rd(a, rv, vv);
    chk_bit(vv, 1'b1);
    chk_byte(rv, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic header();
    header_done[0] = 1'b1;
    wait_cyc(1);
    header_done[0] = 1'b0;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      $display("mismatch at %0t: run too long", $time);
      results();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    wait_cyc(6);
    rst = 1'b0;
    for (int k = 0; k < NUM_CH; k++) begin
      for (int r = 0; r < 6; r++) rd_chk(ra(k, r), rst_tab[r]);
    end
    rd_chk(8'h38, 8'h00);
    chk_byte(8'(lin_clock_enable_q), 8'h00);
    $display("test reset values done");
    for (int r = 0; r < 6; r++) i_lin_host_model.wr(ra(0, r), wr_tab[r]);
    for (int r = 0; r < 6; r++) rd_chk(ra(0, r), ref_tab[r]);
    init_request = 4'hF;
    sleep_select = 4'hF;
    wait_cyc(1);
    chk_byte(8'(init_mode_q), 8'h00);
    i_lin_host_model.wr(ra(0, 3), 8'hFF);
    rd_chk(ra(0, 3), 8'h00);
    sleep_select = 4'h0;
    wait_cyc(1);
    chk_byte(8'(init_mode_q), 8'h0F);
    $display("test refused writes done");
    for (int r = 0; r < 6; r++) i_lin_host_model.wr(ra(3, r), wr_tab[r]);
    for (int r = 0; r < 6; r++) rd_chk(ra(3, r), ini_tab[r]);
    rd_chk(ra(0, 5), 8'h00);
    $display("test init writes done");
    idle_timeout_event[0] = 1'b1;
    wait_cyc(1);
    idle_timeout_event[0] = 1'b0;
    chk_bit(fsm_idle_reset_q[0], 1'b1);
    i_lin_host_model.wr(ra(0, 0), 8'h00);
    idle_timeout_event[0] = 1'b1;
    wait_cyc(1);
    idle_timeout_event[0] = 1'b0;
    chk_bit(fsm_idle_reset_q[0], 1'b0);
    i_lin_host_model.wr(ra(0, 1), 8'h02);
    chk_bit(two_stop_bits_q[0], 1'b1);
    i_lin_host_model.wr(ra(0, 1), 8'h00);
    chk_bit(two_stop_bits_q[0], 1'b0);
    $display("test idle and stop done");
    i_lin_host_model.wr(ra(0, 5), 8'h03);
    i_lin_host_model.wr(ra(0, 3), 8'h08);
    wait_cyc(20);
    chk_bit(lin_clock_enable_q[0], 1'b1);
    repeat (560) begin
      wait_cyc(1);
      ticks += int'(baud_tick_q[0]);
      idle_ticks += int'(baud_tick_q[1]);
    end
    chk_bit(ticks inside {[159:161]}, 1'b1);
    chk_bit(idle_ticks == 0, 1'b1);
    $display("test baud done");
    i_lin_host_model.wr(ra(0, 2), 8'h01);
    header();
    wait_cyc(100);
    chk_bit(timeout_error_flag_q[0], 1'b0);
    wait_cyc(24);
    chk_bit(timeout_error_flag_q[0], 1'b1);
    timeout_flag_clear[0] = 1'b1;
    wait_cyc(1);
    timeout_flag_clear[0] = 1'b0;
    chk_bit(timeout_error_flag_q[0], 1'b0);
    data_byte_count[3:0] = 4'h1;
    header();
    wait_cyc(150);
    chk_bit(timeout_error_flag_q[0], 1'b0);
    response_done[0] = 1'b1;
    wait_cyc(1);
    response_done[0] = 1'b0;
    wait_cyc(100);
    chk_bit(timeout_error_flag_q[0], 1'b0);
    header();
    wait_cyc(180);
    chk_bit(timeout_error_flag_q[0], 1'b1);
    $display("test response timer done");
    i_lin_host_model.wr(ra(0, 1), 8'h01);
    wait_cyc(5);
    chk_bit(soft_reset_q[0], 1'b1);
    chk_bit(timeout_error_flag_q[0], 1'b0);
    ticks = 0;
    repeat (100) begin
      wait_cyc(1);
      ticks += int'(baud_tick_q[0]);
    end
    chk_bit(ticks == 0, 1'b1);
    chk_bit(soft_reset_q[0], 1'b1);
    rd_chk(ra(0, 5), 8'h03);
    i_lin_host_model.wr(ra(0, 1), 8'h00);
    chk_bit(soft_reset_q[0], 1'b0);
    $display("test soft reset done");
    results();
  end
endmodule
bind lin_channel_timing_config lin_cfg_checker i_lin_cfg_checker (.*);
